// ==== dv/dpc_user.sv ====
// user logic model that drives both memory ports
`timescale 1ns/1ns
module dpc_user
    import dpc_pkg::*;
(
    input wire logic core_clk,
    output dpc_req_t [1:0] port_req
);
    initial port_req = '0;

    function automatic dpc_req_t mk(logic rw, logic [11:0] a, logic [63:0] d, logic [8:0] be,
        logic [1:0] inj);
        dpc_req_t r;
        r = '0;
        r.en = 1'b1;
        r.read_write_select = rw;
        r.byte_write_enables = be;
        r.din = {8'h00, d};
        r.addr = {11'h000, a};
        r.single_error_inject = inj[0];
        r.double_error_inject = inj[1];
        return r;
    endfunction

    // enable high only for the taken edge
    task automatic drive(input dpc_req_t a, input dpc_req_t b);
        dpc_req_t ia;
        dpc_req_t ib;
        ia = ~a;
        ib = ~b;
        ia.en = 1'b0;
        ib.en = 1'b0;
        @(posedge core_clk);
        port_req[0] <= a;
        port_req[1] <= b;
        @(posedge core_clk);
        // released fields show junk so stale values are never mistaken for data
        port_req[0] <= ia;
        port_req[1] <= ib;
    endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the dual-port memory block
`timescale 1ns/1ns
module tb;
    import dpc_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic sleep = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0000_0000;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    dpc_req_t [1:0] port_req;
    logic [1:0] array_output_stage_enable = 2'b11;
    logic [1:0] decoder_stage_enable = 2'b11;
    logic [1:0] output_reset = 2'b00;
    dpc_rsp_t [1:0] port_rsp;
    logic clearing;
    logic auto_asleep;
    dpc_req_t [1:0] cas_out_req;
    dpc_rsp_t [1:0] cas_out_rsp;
    dpc_req_t rq;
    int mismatches = 0;
    int total_checks = 0;
    logic [31:0] rd;
    int n;
    localparam logic [63:0] D1 = 64'h0123_4567_89ab_cdef;
    localparam logic [63:0] D2 = 64'hfedc_ba98_7654_3210;
    localparam logic [63:0] B30 = 64'h0000_0000_4000_0000;
    logic [31:0] cf [4] = '{32'h0000_0003, 32'h0000_0007, 32'h0000_000f, 32'h0000_001f};

    always #25 core_clk = ~core_clk;

    dpc_user i_dpc_user (.core_clk(core_clk), .port_req(port_req));

    dpc_ram i_dpc_ram (.core_clk(core_clk), .reset(reset), .sleep(sleep), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .port_req(port_req),
        .array_output_stage_enable(array_output_stage_enable),
        .decoder_stage_enable(decoder_stage_enable), .output_reset(output_reset),
        .port_rsp(port_rsp), .cas_in_req('0), .cas_in_rsp('0), .cas_out_req(cas_out_req),
        .cas_out_rsp(cas_out_rsp), .clearing(clearing), .auto_asleep(auto_asleep));

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic chk(string nm, logic [71:0] e, logic [71:0] g);
        total_checks++;
        if (e !== g)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic fail(string nm);
        chk(nm, 72'h0, 72'h1);
        give_verdict();
    endtask

    task automatic wb(logic we, logic [3:0] a, logic [3:0] s, logic [31:0] d);
        int i;
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= s;
        wb_dat_w <= d;
        i = 0;
        do
        begin
            @(posedge core_clk);
            i++;
        end
        while (wb_ack !== 1'b1 && i < 20);
        if (wb_ack !== 1'b1)
            fail("wb ack");
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic send(int p, dpc_req_t r);
        if (p == 0)
            i_dpc_user.drive(r, '0);
        else
            i_dpc_user.drive('0, r);
    endtask

    task automatic wr(int p, logic [11:0] a, logic [63:0] d, logic [8:0] be, logic [1:0] inj);
        logic [71:0] prev;
        prev = port_rsp[p].dout;
        send(p, i_dpc_user.mk(1'b1, a, d, be, inj));
        @(negedge core_clk);
        chk("dout held", prev, port_rsp[p].dout);
    endtask

    // f is {single, double}; dc selects the data compare
    task automatic rdc(int p, logic [11:0] a, logic [63:0] e, logic [1:0] f, int lat, bit dc);
        int i;
        send(p, i_dpc_user.mk(1'b0, a, 64'h0, 9'h000, 2'b00));
        i = 0;
        do
        begin
            @(negedge core_clk);
            i++;
        end
        while (port_rsp[p].read_access !== 1'b1 && i < 8);
        chk("latency", 72'(lat), 72'(i));
        if (dc)
            chk("dout", 72'(e), 72'(port_rsp[p].dout[63:0]));
        chk("flags", 72'(f), 72'({port_rsp[p].single_error_flag,
            port_rsp[p].double_error_flag}));
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        n = 0;
        while (clearing !== 1'b0 && n < 5000)
        begin
            @(posedge core_clk);
            n++;
        end
        if (clearing !== 1'b0)
            fail("clearing");
        wb(1'b0, 4'h0, 4'hf, 32'h0000_0000);
        chk("config", 72'h03, 72'(rd));
        wb(1'b0, 4'h8, 4'hf, 32'h0000_0000);
        chk("unmapped", 72'h0, 72'(rd));
        rdc(0, 12'hfff, 64'h0, 2'b00, 1, 1'b1);
        rdc(1, 12'h000, 64'h0, 2'b00, 1, 1'b1);
        wr(0, 12'h005, D1, 9'h1ff, 2'b00);
        rdc(1, 12'h005, D1, 2'b00, 1, 1'b1);
        wr(1, 12'h005, D2, 9'h001, 2'b00);
        rdc(0, 12'h005, {D1[63:8], D2[7:0]}, 2'b00, 1, 1'b1);
        // a write on A and a read on B of one word in the same cycle
        i_dpc_user.drive(i_dpc_user.mk(1'b1, 12'h007, D2, 9'h1ff, 2'b00),
            i_dpc_user.mk(1'b0, 12'h007, 64'h0, 9'h000, 2'b00));
        @(negedge core_clk);
        chk("same word", 72'(D2), 72'(port_rsp[1].dout[63:0]));
        chk("a held", 72'({D1[63:8], D2[7:0]}), 72'(port_rsp[0].dout[63:0]));
        i_dpc_user.drive(i_dpc_user.mk(1'b1, 12'h008, D1, 9'h1ff, 2'b00),
            i_dpc_user.mk(1'b1, 12'h008, D2, 9'h1ff, 2'b00));
        rdc(0, 12'h008, D2, 2'b00, 1, 1'b1);
        // a full write request with only its enable low
        rq = i_dpc_user.mk(1'b1, 12'h00a, D1, 9'h1ff, 2'b00);
        rq.en = 1'b0;
        send(0, rq);
        rdc(0, 12'h00a, 64'h0, 2'b00, 1, 1'b1);
        @(posedge core_clk);
        sleep <= 1'b1;
        send(0, i_dpc_user.mk(1'b1, 12'h00b, D1, 9'h1ff, 2'b00));
        sleep <= 1'b0;
        rdc(0, 12'h00b, 64'h0, 2'b00, 1, 1'b1);
        // encoder only: stored flip shows raw, no flags
        wb(1'b1, 4'h0, 4'h1, 32'h0000_0001);
        wr(0, 12'h00c, D1, 9'h1ff, 2'b01);
        rdc(0, 12'h00c, D1 ^ B30, 2'b00, 1, 1'b1);
        wb(1'b1, 4'h0, 4'h1, 32'h0000_0003);
        rdc(0, 12'h00c, D1, 2'b10, 1, 1'b1);
        wr(0, 12'h00d, D1, 9'h1ff, 2'b11);
        rdc(0, 12'h00d, D1, 2'b01, 1, 1'b0);
        wb(1'b0, 4'h4, 4'hf, 32'h0000_0000);
        chk("status", 72'h300, 72'(rd));
        wb(1'b1, 4'h4, 4'h2, 32'h0000_0300);
        wb(1'b0, 4'h4, 4'hf, 32'h0000_0000);
        chk("status clr", 72'h0, 72'(rd));
        for (int k = 0; k < 4; k++)
        begin
            wb(1'b1, 4'h0, 4'h1, cf[k]);
            wr(0, 12'h00e, D2, 9'h1ff, 2'b00);
            repeat (6) @(posedge core_clk);
            rdc(0, 12'h00e, D2, 2'b00, k + 1, 1'b1);
        end
        // reset must win over low clock enables
        @(posedge core_clk);
        array_output_stage_enable <= 2'b00;
        decoder_stage_enable <= 2'b00;
        output_reset <= 2'b10;
        @(posedge core_clk);
        output_reset <= 2'b00;
        @(negedge core_clk);
        chk("out reset", 72'h0, port_rsp[1].dout);
        // async clear shows on the outputs before the next edge
        wb(1'b1, 4'h0, 4'h1, 32'h0000_0023);
        @(posedge core_clk);
        output_reset <= 2'b01;
        @(negedge core_clk);
        chk("async reset", 72'h0, port_rsp[0].dout);
        @(posedge core_clk);
        output_reset <= 2'b00;
        array_output_stage_enable <= 2'b11;
        decoder_stage_enable <= 2'b11;
        // auto sleep after an idle stretch, woken by the next access
        wb(1'b1, 4'h0, 4'h1, 32'h0000_0043);
        repeat (80) @(posedge core_clk);
        wb(1'b0, 4'h4, 4'hf, 32'h0000_0000);
        chk("sleep status", 72'h002, 72'(rd));
        chk("asleep", 72'h1, 72'(auto_asleep));
        rdc(0, 12'h00e, D2, 2'b00, 1, 1'b1);
        chk("awake", 72'h0, 72'(auto_asleep));
        chk("cascade dout", 72'(D2), 72'(cas_out_rsp[0].dout[63:0]));
        chk("cascade req", 72'(port_req[0].addr), 72'(cas_out_req[0].addr));
        give_verdict();
    end
endmodule

// ==== src/dpc_defines.svh ====
// constants for the dual-port cascadable memory block
//
// Function
// - array holds 4096 words of 72 bits
// - one clock; each port reads or writes
// - port A operation completes before port B
// - writing port keeps its read outputs unchanged
// - read latency selectable from one to four
// - per-port encoder and decoder, 64 data bits
// - write may inject single or double error
// - encoder and decoder enabled independently
// - optional decoder stage with own enable
// - output reset clears read outputs to zero
// - array cleared to zero after reset
// - port data width fixed at 72 bits
// - cascade decodes 11 upper address bits
// - cascade flows only from lower to upper
// - cascade carries request, data and status
// - cascade routing fixed, no runtime muxes
// - read behaviour fixed, no policy choice
// - sleep ignores operations, keeps contents
// - auto sleep follows chain activity
// - byte write enables select updated bytes
// - nine byte enables, one per lane
// - output reset async or sync, beats enable
// - port enable gates all array access
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH
`define DPC_LAST_WORD 12'h0FFF
`define DPC_INJ_BIT_LO 30
`define DPC_INJ_BIT_HI 62
`define DPC_IDLE_LIMIT 8'h40
`define DPC_CFG_OFS 4'h0
`define DPC_STAT_OFS 4'h4
`define DPC_CFG_RESET 7'h03
`define DPC_STAT_CLR_POS 8
`endif

// ==== src/dpc_pkg.sv ====
// types shared by the dual-port cascadable memory block
package dpc_pkg;
    typedef enum logic [0:0] {PH_CLEAR = 1'b0, PH_RUN = 1'b1} dpc_phase_t;

    typedef struct packed {
        logic en;
        logic read_write_select;
        logic [8:0] byte_write_enables;
        logic [71:0] din;
        logic [22:0] addr;
        logic single_error_inject;
        logic double_error_inject;
    } dpc_req_t;

    typedef struct packed {
        logic [71:0] dout;
        logic read_access;
        logic single_error_flag;
        logic double_error_flag;
    } dpc_rsp_t;

    typedef struct packed {
        logic v;
        logic s;
        logic d;
        logic [71:0] w;
    } dpc_stage_t;

    typedef struct packed {
        dpc_stage_t st0;
        dpc_stage_t st1;
        dpc_stage_t st2;
        dpc_stage_t st3;
    } dpc_pipe_t;

    typedef struct packed {
        logic auto_sleep;
        logic async_rst;
        logic out_stg;
        logic dec_stg;
        logic arr_stg;
        logic dec;
        logic enc;
    } dpc_cfg_t;

    typedef struct packed {
        dpc_phase_t phase;
        logic [11:0] clr_addr;
        logic [7:0] idle_cnt;
        logic asleep;
        dpc_cfg_t cfg;
        logic [3:0] err_seen;
        logic ack;
        logic [31:0] rdat;
        dpc_pipe_t [1:0] pp;
    } dpc_state_t;
endpackage

// ==== src/dpc_ram.sv ====
// dual-port 4096 x 72 memory with ecc, pipeline, cascade and sleep
`timescale 1ns/1ns
`include "dpc_defines.svh"
module dpc_ram
    import dpc_pkg::*;
#(
    parameter bit CHAIN_FIRST = 1'b1,
    parameter bit CHAIN_DECODE = 1'b0,
    parameter logic [10:0] BLOCK_INDEX = 11'h000
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sleep,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [3:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire dpc_req_t [1:0] port_req,
    input wire logic [1:0] array_output_stage_enable,
    input wire logic [1:0] decoder_stage_enable,
    input wire logic [1:0] output_reset,
    output dpc_rsp_t [1:0] port_rsp,
    input wire dpc_req_t [1:0] cas_in_req,
    input wire dpc_rsp_t [1:0] cas_in_rsp,
    output dpc_req_t [1:0] cas_out_req,
    output dpc_rsp_t [1:0] cas_out_rsp,
    output logic clearing,
    output logic auto_asleep
);
    // ------------------------------------------------------------
    // error-correcting code
    // ------------------------------------------------------------
    function automatic logic [7:0] ecc_enc(input logic [63:0] dat);
        logic [7:0] p;
        int k;
        p = '0;
        k = 0;
        for (int pos = 1; pos < 72; pos++)
        begin
            if ((pos & (pos - 1)) != 0)
            begin
                for (int b = 0; b < 7; b++)
                begin
                    if (pos[b])
                    begin
                        p[b] = p[b] ^ dat[k];
                    end
                end
                k++;
            end
        end
        p[7] = (^dat) ^ (^p[6:0]);
        return p;
    endfunction

    // single flips are corrected on the way out only, never in the array
    function automatic dpc_stage_t ecc_dec(input dpc_stage_t in);
        dpc_stage_t o;
        logic [7:0] chk;
        logic [6:0] syn;
        logic odd;
        int k;
        o = in;
        chk = ecc_enc(in.w[63:0]);
        syn = chk[6:0] ^ in.w[70:64];
        odd = ^in.w;
        k = 0;
        o.s = odd;
        o.d = !odd && (syn != 7'h00);
        for (int pos = 1; pos < 72; pos++)
        begin
            if ((pos & (pos - 1)) != 0)
            begin
                if (odd && syn == pos[6:0])
                begin
                    o.w[k] = !in.w[k];
                end
                k++;
            end
            else
            begin
                for (int b = 0; b < 7; b++)
                begin
                    if (odd && pos == (1 << b) && syn == pos[6:0])
                    begin
                        o.w[64 + b] = !in.w[64 + b];
                    end
                end
            end
        end
        if (odd && syn == 7'h00)
        begin
            o.w[71] = !in.w[71];
        end
        return o;
    endfunction

    // ------------------------------------------------------------
    // array and request selection
    // ------------------------------------------------------------
    logic [71:0] mem [4096];
    dpc_state_t q, d;
    dpc_req_t [1:0] r;
    logic [1:0] hit, op, we, re;
    logic [71:0] base [2];
    logic [71:0] wword [2];
    logic [71:0] enc_word [2];
    dpc_stage_t [1:0] a1, dec, a2, own;
    logic [3:0] err_set, err_clr;
    logic wb_take;

    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            r[p] = CHAIN_FIRST ? port_req[p] : cas_in_req[p];
            hit[p] = !CHAIN_DECODE || (r[p].addr[22:12] == BLOCK_INDEX);
            op[p] = r[p].en && hit[p] && !sleep && q.phase == PH_RUN;
            we[p] = op[p] && r[p].read_write_select;
            re[p] = op[p] && !r[p].read_write_select;
        end
    end

    // requests pass straight up the chain
    // request and data travel with status
    assign cas_out_req = r;

    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            // port B sees port A result
            if (p == 1 && we[0] && r[0].addr[11:0] == r[1].addr[11:0])
            begin
                base[p] = wword[0];
            end
            else
            begin
                base[p] = mem[r[p].addr[11:0]];
            end
            wword[p] = base[p];
            for (int b = 0; b < 9; b++)
            begin
                if (r[p].byte_write_enables[b])
                begin
                    wword[p][8 * b +: 8] = r[p].din[8 * b +: 8];
                end
            end
            enc_word[p] = {ecc_enc(wword[p][63:0]), wword[p][63:0]};
            if (q.cfg.enc)
            begin
                wword[p] = enc_word[p];
            end
            if (r[p].single_error_inject || r[p].double_error_inject)
            begin
                wword[p][`DPC_INJ_BIT_LO] = !wword[p][`DPC_INJ_BIT_LO];
            end
            if (r[p].double_error_inject)
            begin
                wword[p][`DPC_INJ_BIT_HI] = !wword[p][`DPC_INJ_BIT_HI];
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (q.phase == PH_CLEAR)
        begin
            mem[q.clr_addr] <= '0;
        end
        else
        begin
            for (int p = 0; p < 2; p++)
            begin
                if (we[p])
                begin
                    mem[r[p].addr[11:0]] <= wword[p];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    assign wb_take = wb_cyc && wb_stb && !q.ack;

    always_comb
    begin
        d = q;
        err_set = '0;
        err_clr = '0;
        if (q.phase == PH_CLEAR)
        begin
            d.clr_addr = q.clr_addr + 12'h001;
            if (q.clr_addr == `DPC_LAST_WORD)
            begin
                d.phase = PH_RUN;
            end
        end
        for (int p = 0; p < 2; p++)
        begin
            d.pp[p].st0.v = re[p];
            if (re[p])
            begin
                d.pp[p].st0.w = base[p];
            end
            a1[p] = q.cfg.arr_stg ? q.pp[p].st1 : q.pp[p].st0;
            dec[p] = q.cfg.dec ? ecc_dec(a1[p]) : a1[p];
            if (!q.cfg.dec)
            begin
                dec[p].s = 1'b0;
                dec[p].d = 1'b0;
            end
            a2[p] = q.cfg.dec_stg ? q.pp[p].st2 : dec[p];
            own[p] = q.cfg.out_stg ? q.pp[p].st3 : a2[p];
            if (array_output_stage_enable[p])
            begin
                d.pp[p].st1 = q.pp[p].st0;
                d.pp[p].st3 = a2[p];
            end
            if (decoder_stage_enable[p])
            begin
                d.pp[p].st2 = dec[p];
            end
            if (output_reset[p])
            begin
                d.pp[p] = '0;
            end
            err_set[2 * p] = own[p].v && own[p].s;
            err_set[2 * p + 1] = own[p].v && own[p].d;
        end
        // sleep after idle chain, wake on any enable
        if (r[0].en || r[1].en || !q.cfg.auto_sleep)
        begin
            d.idle_cnt = '0;
            d.asleep = 1'b0;
        end
        else if (q.idle_cnt == `DPC_IDLE_LIMIT)
        begin
            d.asleep = 1'b1;
        end
        else
        begin
            d.idle_cnt = q.idle_cnt + 8'h01;
        end
        d.ack = wb_take;
        d.rdat = '0;
        if (wb_take)
        begin
            unique case (wb_adr)
                `DPC_CFG_OFS:
                begin
                    d.rdat = {25'h000_0000, q.cfg};
                    if (wb_we && wb_sel[0])
                    begin
                        d.cfg = dpc_cfg_t'(wb_dat_w[6:0]);
                    end
                end
                `DPC_STAT_OFS:
                begin
                    d.rdat = {20'h0_0000, q.err_seen, 5'h00, sleep, q.asleep,
                        q.phase == PH_CLEAR};
                    if (wb_we && wb_sel[1])
                    begin
                        err_clr = wb_dat_w[`DPC_STAT_CLR_POS +: 4];
                    end
                end
                default:
                begin
                    d.rdat = '0;
                end
            endcase
        end
        // a flag raised in the clearing cycle survives the clear
        d.err_seen = (q.err_seen & ~err_clr) | err_set;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            q <= '0;
            q.phase <= PH_CLEAR;
            q.cfg <= dpc_cfg_t'(`DPC_CFG_RESET);
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            port_rsp[p] = '{dout: own[p].w, read_access: own[p].v,
                single_error_flag: own[p].v && own[p].s,
                double_error_flag: own[p].v && own[p].d};
            if (!CHAIN_FIRST && cas_in_rsp[p].read_access && !own[p].v)
            begin
                port_rsp[p] = cas_in_rsp[p];
            end
            // asynchronous clear of outputs when chosen
            if (q.cfg.async_rst && output_reset[p])
            begin
                port_rsp[p] = '0;
            end
        end
    end

    assign cas_out_rsp = port_rsp;
    assign wb_ack = q.ack;
    assign wb_dat_r = q.rdat;
    assign clearing = q.phase == PH_CLEAR;
    assign auto_asleep = q.asleep;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence s_plain_read;
        re[0] && q.cfg[4:1] == 4'b0000;
    endsequence

    sequence s_answer;
        port_rsp[0].read_access && port_rsp[0].dout == $past(base[0]);
    endsequence

    a_write_holds_data: assert property (
        we[0] && !re[0] && !output_reset[0] |=> q.pp[0].st0.w == $past(q.pp[0].st0.w)
        && !q.pp[0].st0.v)
        else $error("write changed port read data");

    a_outrst_zero: assert property (
        output_reset[1] |=> q.pp[1] == '0)
        else $error("output reset did not clear stages");

    a_sleep_no_op: assert property (
        sleep |-> we == 2'b00 && re == 2'b00)
        else $error("operation taken while asleep");

    a_clear_sweep: assert property (
        q.phase == PH_CLEAR && q.clr_addr != `DPC_LAST_WORD
        |=> q.phase == PH_CLEAR && q.clr_addr == $past(q.clr_addr) + 12'h001)
        else $error("clear sweep skipped a word");

    a_forward_same: assert property (
        we[0] && re[1] && r[0].addr[11:0] == r[1].addr[11:0] |-> base[1] == wword[0])
        else $error("port B missed port A write");

    a_decode_gate: assert property (
        op[0] |-> !CHAIN_DECODE || r[0].addr[22:12] == BLOCK_INDEX)
        else $error("operation outside block range");

    a_double_inject: assert property (
        we[0] && q.cfg.enc && r[0].double_error_inject && r[0].byte_write_enables == 9'h1FF
        |-> (wword[0] ^ enc_word[0]) == ((72'h1 << `DPC_INJ_BIT_LO) | (72'h1 << `DPC_INJ_BIT_HI)))
        else $error("double injection pattern wrong");

    a_latency_one: assert property (
        s_plain_read ##0 !output_reset[0] ##1 !q.cfg.async_rst |-> s_answer)
        else $error("one-cycle read latency broken");

    a_flags_off: assert property (
        !q.cfg.dec && !q.cfg.dec_stg && !q.cfg.out_stg |-> !port_rsp[0].single_error_flag
        && !port_rsp[0].double_error_flag)
        else $error("flag raised with decoder off");

    a_enable_gate: assert property (
        !r[1].en |-> !we[1] && !re[1])
        else $error("access without port enable");
endmodule
